// >>> hw/dpm_port_host.sv
/*
 * Host for one port of an asynchronous dual-port memory with mailbox,
 * busy arbitration and eight token latches. One command at a time.
 * Assumes the pins are asynchronous to sys_clk, so busy, interrupt and
 * read data pass two flip-flops; the device keeps its own arbitration.
 */
`timescale 1ns/1ps
`include "dpm_params.svh"

module dpm_port_host #(
    parameter int ADDR_W = 13,
    parameter int DATA_W = 8,
    parameter bit LEFT_PORT = 1'b1
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic cmdValid,
    output logic cmdReady,
    input wire dpm_pkg::op_t cmdOp,
    input wire logic [ADDR_W-1:0] cmdAddr,
    input wire logic [DATA_W-1:0] cmdData,
    output logic rspValid,
    output logic [DATA_W-1:0] rspData,
    output logic rspGranted,
    output logic rspStalled,
    output logic initDone,
    output logic mailboxPending,
    output logic chipEnN,
    output logic tokenEnN,
    output logic rdWrN,
    output logic outEnN,
    output logic [ADDR_W-1:0] addrPin,
    input wire logic [DATA_W-1:0] dataIn,
    output logic [DATA_W-1:0] dataOut,
    output logic dataOe,
    input wire logic busyInN,
    input wire logic intInN
);
    generate
        if (ADDR_W != 13 || DATA_W < 8 || DATA_W > 9) begin : g_bad
            $error("dpm_port_host: needs 13 address bits and 8 or 9 data bits");
        end
    endgenerate

    dpm_timer_if tmr ();
    dpm_pace_timer u_pace (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .tmr(tmr.pacer)
    );

    // pin synchronisers, first stage read only by the second
    // busy in a wide system is the master's busy output [R11]
    logic busyMeta, busySync, intMeta, intSync;
    logic [DATA_W-1:0] dataMeta, dataSync;
    always_ff @(posedge sys_clk) begin
        busyMeta <= busyInN;
        busySync <= busyMeta;
        intMeta <= intInN;
        intSync <= intMeta;
        dataMeta <= dataIn;
        dataSync <= dataMeta;
    end

    dpm_pkg::state_t state;
    dpm_pkg::op_t op;
    logic initPending;
    logic [2:0] initIdx;
    logic tmrLoad;
    logic [`DPM_TMR_W-1:0] tmrCount;

    assign tmr.load = tmrLoad;
    assign tmr.count = tmrCount;
    assign cmdReady = (state == dpm_pkg::ST_IDLE) && !initPending;
    assign initDone = !initPending;
    // interrupt low means the other port left a message for us
    assign mailboxPending = !intSync; // [R4] [R6]

    wire logic takeCmd = cmdValid && cmdReady;
    wire logic startInit = (state == dpm_pkg::ST_IDLE) && initPending;
    wire logic startAny = takeCmd || startInit;
    wire dpm_pkg::op_t startOp = startInit ? dpm_pkg::OP_TOKEN_GIVE : cmdOp;
    wire logic [ADDR_W-1:0] startAddr = startInit ? ADDR_W'(initIdx) : cmdAddr;
    wire logic startToken = (startOp == dpm_pkg::OP_TOKEN_TAKE)
        || (startOp == dpm_pkg::OP_TOKEN_GIVE) || (startOp == dpm_pkg::OP_TOKEN_POLL);
    // request writes 0, release or withdrawal writes 1, on every line
    wire logic [DATA_W-1:0] tokenWord =
        (startOp == dpm_pkg::OP_TOKEN_TAKE) ? '0 : '1; // [R14] [R18]
    wire logic busyLow = !busySync;
    wire logic tmrDone = tmr.done;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state <= dpm_pkg::ST_IDLE;
            op <= dpm_pkg::OP_MEM_RD;
            initPending <= 1'b1;
            initIdx <= 3'h0;
            tmrLoad <= 1'b0;
            tmrCount <= '0;
            chipEnN <= 1'b1;
            tokenEnN <= 1'b1;
            rdWrN <= 1'b1;
            outEnN <= 1'b1;
            addrPin <= '0;
            dataOut <= '0;
            dataOe <= 1'b0;
            rspValid <= 1'b0;
            rspData <= '0;
            rspGranted <= 1'b0;
            rspStalled <= 1'b0;
        end else begin
            tmrLoad <= 1'b0;
            rspValid <= 1'b0;
            unique case (state)
                dpm_pkg::ST_IDLE: begin
                    if (startAny) begin
                        op <= startOp;
                        addrPin <= startAddr;
                        rspStalled <= 1'b0;
                        tmrLoad <= 1'b1;
                        // selects are exclusive: never both low together
                        if (startToken) begin // [R23]
                            tokenEnN <= 1'b0; // [R13]
                            if (startOp == dpm_pkg::OP_TOKEN_POLL) begin
                                outEnN <= 1'b0;
                                tmrCount <= `DPM_TMR_W'(`DPM_TOKEN_RD_CYC);
                                state <= dpm_pkg::ST_TOKEN_RD;
                            end else begin
                                rdWrN <= 1'b0;
                                dataOut <= tokenWord;
                                dataOe <= 1'b1;
                                tmrCount <= `DPM_TMR_W'(`DPM_WR_CYC);
                                state <= dpm_pkg::ST_TOKEN_WR;
                            end
                        end else if (startOp == dpm_pkg::OP_MEM_RD) begin
                            // far-port data only valid a flow delay after its write [R1]
                            chipEnN <= 1'b0; // [R2]
                            outEnN <= 1'b0; // [R2]
                            tmrCount <= `DPM_TMR_W'(`DPM_ACCESS_CYC);
                            state <= dpm_pkg::ST_MEM_RD;
                        end else begin
                            // select with write high first, let busy settle
                            chipEnN <= 1'b0;
                            dataOut <= cmdData; // [R7]
                            tmrCount <= `DPM_TMR_W'(`DPM_SETTLE_CYC);
                            state <= dpm_pkg::ST_ARB;
                        end
                        if (startInit) begin
                            initIdx <= initIdx + 3'h1; // [R22]
                            initPending <= (initIdx != 3'h7);
                        end
                    end
                end
                dpm_pkg::ST_ARB: begin
                    if (tmrDone) begin
                        if (busyLow) begin // [R12]
                            rspStalled <= 1'b1;
                            state <= dpm_pkg::ST_WAIT_FREE;
                        end else begin
                            rdWrN <= 1'b0;
                            dataOe <= 1'b1;
                            tmrLoad <= 1'b1;
                            tmrCount <= `DPM_TMR_W'(`DPM_WR_CYC);
                            state <= dpm_pkg::ST_MEM_WR;
                        end
                    end
                end
                dpm_pkg::ST_WAIT_FREE: begin
                    // re-settle after release rather than trusting one sample
                    if (!busyLow) begin // [R12]
                        tmrLoad <= 1'b1;
                        tmrCount <= `DPM_TMR_W'(`DPM_SETTLE_CYC);
                        state <= dpm_pkg::ST_ARB;
                    end
                end
                dpm_pkg::ST_MEM_WR: begin
                    if (tmrDone) begin
                        rdWrN <= 1'b1;
                        chipEnN <= 1'b1;
                        state <= dpm_pkg::ST_DONE;
                    end
                end
                dpm_pkg::ST_MEM_RD: begin
                    if (tmrDone) begin
                        rspData <= dataSync;
                        chipEnN <= 1'b1;
                        outEnN <= 1'b1;
                        state <= dpm_pkg::ST_DONE;
                    end
                end
                dpm_pkg::ST_TOKEN_WR: begin
                    if (tmrDone) begin
                        rdWrN <= 1'b1;
                        tokenEnN <= 1'b1;
                        tmrLoad <= 1'b1;
                        tmrCount <= `DPM_TMR_W'(`DPM_GAP_CYC);
                        state <= dpm_pkg::ST_TOKEN_GAP;
                    end
                end
                dpm_pkg::ST_TOKEN_GAP: begin
                    dataOe <= 1'b0;
                    // gap after every token write: the next command may be a poll
                    if (tmrDone) begin // [R21]
                        if (op == dpm_pkg::OP_TOKEN_TAKE) begin
                            tokenEnN <= 1'b0;
                            outEnN <= 1'b0;
                            tmrLoad <= 1'b1;
                            tmrCount <= `DPM_TMR_W'(`DPM_TOKEN_RD_CYC);
                            state <= dpm_pkg::ST_TOKEN_RD;
                        end else begin
                            state <= dpm_pkg::ST_DONE;
                        end
                    end
                end
                dpm_pkg::ST_TOKEN_RD: begin
                    if (tmrDone) begin
                        rspData <= dataSync; // [R19]
                        // bit 0 low means this port owns the token
                        rspGranted <= !dataSync[0]; // [R15] [R16] [R20]
                        tokenEnN <= 1'b1;
                        outEnN <= 1'b1;
                        state <= dpm_pkg::ST_DONE;
                    end
                end
                dpm_pkg::ST_DONE: begin
                    dataOe <= 1'b0;
                    rspValid <= 1'b1;
                    state <= dpm_pkg::ST_IDLE;
                end
            endcase
        end
    end
endmodule : dpm_port_host

// >>> hw/dpm_params.svh
/*
 * Constants for the dual-port memory port host: pin timing in ns,
 * derived cycle counts, mailbox and semaphore addressing.
 * Assumes a 4 ns system clock and the fastest speed grade of the memory.
 */
// Notes on behaviour
// [R1] cross-port data valid only after flow delay
// [R2] reads drive output enable and chip enable
// [R3] left write of 1FFF flags right port
// [R4] right read of 1FFF clears its flag
// [R5] right write of 1FFE flags left port
// [R6] left read of 1FFE clears its flag
// [R7] mailbox words are plain user data
// [R8] same-address contention grants exactly one port
// [R9] loser busy follows address match, bounded delay
// [R10] mode pin selects busy output or input
// [R11] master busy outputs feed every slave input
// [R12] slave writes wait for busy to settle
// [R13] eight token latches, low address bits select
// [R14] token write uses bit 0 only
// [R15] taking free token shows 0 here, 1 there
// [R16] pending request wins at owner release
// [R17] release without request frees token
// [R18] withdraw an unwanted request by writing 1
// [R19] token read drives all lines, latched
// [R20] simultaneous requests award exactly one port
// [R21] gap between token write and readback
// [R22] release all tokens from both ports at start
// [R23] never select memory and token together
// [R24] deselected or output-disabled port floats data; the device model drives the inverted last read value instead
// [R25] busy input low blocks slave writes
`ifndef DPM_PARAMS_SVH
`define DPM_PARAMS_SVH

`define DPM_CLK_NS 4
`define DPM_CYC_UP(ns) (((ns) + `DPM_CLK_NS - 1) / `DPM_CLK_NS)
`define DPM_SYNC_CYC 2

`define DPM_SELECT_TO_DATA_NS 15
`define DPM_OUTPUT_ENABLE_TO_DATA_NS 10
`define DPM_WR_PULSE_NS 12
`define DPM_BUSY_SETTLE_NS 15
`define DPM_CROSS_PORT_FLOW_DELAY_NS 25
`define DPM_TOKEN_UPDATE_GAP_NS 10
`define DPM_TOKEN_WRITE_TO_READ_GAP_NS 5

`define DPM_TMR_W 4
`define DPM_ACCESS_CYC (`DPM_CYC_UP(`DPM_SELECT_TO_DATA_NS) + `DPM_SYNC_CYC)
`define DPM_WR_CYC `DPM_CYC_UP(`DPM_WR_PULSE_NS)
`define DPM_SETTLE_CYC (`DPM_CYC_UP(`DPM_BUSY_SETTLE_NS) + `DPM_SYNC_CYC)
`define DPM_GAP_CYC `DPM_CYC_UP(`DPM_TOKEN_UPDATE_GAP_NS)
`define DPM_TOKEN_RD_CYC (`DPM_CYC_UP(`DPM_TOKEN_WRITE_TO_READ_GAP_NS \
    + `DPM_OUTPUT_ENABLE_TO_DATA_NS) + `DPM_SYNC_CYC)
`define DPM_FLOW_CYC `DPM_CYC_UP(`DPM_CROSS_PORT_FLOW_DELAY_NS)

`define DPM_MAIL_TOP 13'h1FFF
`define DPM_MAIL_LOW 13'h1FFE
`define DPM_TOKEN_COUNT 8

`endif

// >>> hw/dpm_pkg.sv
/*
 * Types shared by the port host and its self-checking bench.
 * Assumes nothing of its surroundings.
 */
package dpm_pkg;
    typedef enum logic [2:0] {
        OP_MEM_RD,
        OP_MEM_WR,
        OP_TOKEN_TAKE,
        OP_TOKEN_GIVE,
        OP_TOKEN_POLL
    } op_t;

    typedef enum {
        ST_IDLE,
        ST_ARB,
        ST_WAIT_FREE,
        ST_MEM_WR,
        ST_MEM_RD,
        ST_TOKEN_WR,
        ST_TOKEN_GAP,
        ST_TOKEN_RD,
        ST_DONE
    } state_t;
endpackage : dpm_pkg

// >>> hw/dpm_timer_if.sv
/*
 * Carrier between the port host and its pacing timer.
 * Assumes both ends run on sys_clk.
 */
`timescale 1ns/1ps
`include "dpm_params.svh"

interface dpm_timer_if;
    logic load;
    logic [`DPM_TMR_W-1:0] count;
    logic done;
    modport owner (output load, output count, input done);
    modport pacer (input load, input count, output done);
endinterface : dpm_timer_if

// >>> hw/dpm_pace_timer.sv
/*
 * Down counter pacing each pin phase of the port host.
 * Assumes load is a one-cycle pulse; done pulses in the last cycle.
 */
`timescale 1ns/1ps
`include "dpm_params.svh"

module dpm_pace_timer (
    input wire logic sys_clk,
    input wire logic sys_rst,
    dpm_timer_if.pacer tmr
);
    logic [`DPM_TMR_W-1:0] cnt;

    assign tmr.done = (cnt == `DPM_TMR_W'(1));

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cnt <= '0;
        end else if (tmr.load) begin
            cnt <= tmr.count;
        end else if (cnt != '0) begin
            cnt <= cnt - `DPM_TMR_W'(1);
        end
    end
endmodule : dpm_pace_timer

// >>> tb/dpm_port_host_sva.sv
/*
 * Pin checker for the port host, bound to every dpm_port_host.
 * Assumes one clock domain and the registered pin timing of the host.
 */
`timescale 1ns/1ps

module dpm_port_host_sva #(
    parameter int ADDR_W = 13,
    parameter int DATA_W = 8
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic rspValid,
    input wire logic rspGranted,
    input wire logic rspStalled,
    input wire logic chipEnN,
    input wire logic tokenEnN,
    input wire logic rdWrN,
    input wire logic outEnN,
    input wire logic [DATA_W-1:0] dataOut,
    input wire logic dataOe,
    input wire logic busyInN
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    property p_one_select;
        !(!chipEnN && !tokenEnN);
    endproperty
    a_one_select: assert property (p_one_select)
        else $error("memory and token selected together");
    property p_write_driven;
        !rdWrN |-> dataOe && (chipEnN != tokenEnN);
    endproperty
    a_write_driven: assert property (p_write_driven)
        else $error("write strobe without one select and driven data");
    property p_no_fight;
        dataOe |-> outEnN;
    endproperty
    a_no_fight: assert property (p_no_fight)
        else $error("data driven while device outputs enabled");
    property p_read_select;
        !outEnN |-> rdWrN && (chipEnN != tokenEnN);
    endproperty
    a_read_select: assert property (p_read_select)
        else $error("output enable without exactly one select");
    property p_read_len;
        $fell(outEnN) |-> !outEnN [*7] ##1 outEnN;
    endproperty
    a_read_len: assert property (p_read_len)
        else $error("read window not seven cycles");
    property p_token_data;
        !tokenEnN && !rdWrN |-> dataOut == '0 || dataOut == '1;
    endproperty
    a_token_data: assert property (p_token_data)
        else $error("token write data not all zeros or all ones");
    property p_token_gap;
        $rose(tokenEnN) && !$past(rdWrN) |-> tokenEnN [*3];
    endproperty
    a_token_gap: assert property (p_token_gap)
        else $error("token readback too soon after write");
    property p_busy_block;
        $fell(rdWrN) && !chipEnN |-> $past(busyInN, 3) && $past(busyInN, 4);
    endproperty
    a_busy_block: assert property (p_busy_block)
        else $error("memory write started while busy low");
    property p_rsp_pulse;
        rspValid |=> !rspValid;
    endproperty
    a_rsp_pulse: assert property (p_rsp_pulse)
        else $error("response pulse longer than one cycle");
    c_granted: cover property ($rose(rspGranted));
    c_mem_write: cover property ($fell(rdWrN) && !chipEnN);
    c_stalled: cover property (rspStalled && rspValid);
endmodule : dpm_port_host_sva

bind dpm_port_host dpm_port_host_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk_u (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .rspValid(rspValid), .rspGranted(rspGranted),
    .rspStalled(rspStalled), .chipEnN(chipEnN), .tokenEnN(tokenEnN), .rdWrN(rdWrN),
    .outEnN(outEnN), .dataOut(dataOut), .dataOe(dataOe), .busyInN(busyInN));

// >>> tb/dpm_device_model.sv
/*
 * Left-port view of the dual-port memory: array, mailbox flags, tokens.
 * Assumes pins change after rising edges; it samples on falling edges.
 */
`timescale 1ns/1ps
`include "dpm_params.svh"

module dpm_device_model (
    input wire logic sys_clk,
    input wire logic chipEnN,
    input wire logic tokenEnN,
    input wire logic rdWrN,
    input wire logic outEnN,
    input wire logic [12:0] addrPin,
    input wire logic [7:0] dataOut,
    output logic [7:0] dataIn,
    output logic intInN,
    output logic otherIntN,
    input wire logic [7:0] farReq,
    input wire logic farSetInt,
    input wire logic farClrInt
);
    logic [7:0] mem [0:8191];
    logic [1:0] own [0:7]; // 0 free, 1 this port, 2 far port
    logic [7:0] pendFar = 8'h00, pendHere = 8'h00, reqPrev = 8'h00, lastOut = 8'h00;
    logic wrMem = 1'b0, wrTok = 1'b0, readNow;
    logic [12:0] wrAddr;
    logic [7:0] wrData, rdVal;
    // no power-up reset: all start held here until released
    initial foreach (own[i]) own[i] = 2'h1;
    initial intInN = 1'b1;
    initial otherIntN = 1'b1;
    assign readNow = rdWrN && !outEnN && (chipEnN != tokenEnN);
    assign rdVal = !chipEnN ? mem[addrPin] : {8{own[addrPin[2:0]] != 2'h1}};
    // released bus shows inverted last value, never a stale copy
    assign dataIn = readNow ? rdVal : ~lastOut;
    task automatic tok_write(input int i, input logic b);
        if (!b) begin
            if (own[i] == 2'h0) own[i] = 2'h1;
            else if (own[i] == 2'h2) pendHere[i] = 1'b1;
        end else begin
            pendHere[i] = 1'b0;
            if (own[i] == 2'h1) own[i] = pendFar[i] ? 2'h2 : 2'h0;
            if (own[i] == 2'h2) pendFar[i] = 1'b0;
        end
    endtask : tok_write
    task automatic far_edge(input int i, input logic r);
        if (r) begin
            if (own[i] == 2'h0) own[i] = 2'h2;
            else if (own[i] == 2'h1) pendFar[i] = 1'b1;
        end else begin
            pendFar[i] = 1'b0;
            if (own[i] == 2'h2) own[i] = pendHere[i] ? 2'h1 : 2'h0;
            pendHere[i] = 1'b0;
        end
    endtask : far_edge
    always @(negedge sys_clk) begin
        if (readNow) lastOut <= rdVal;
        if (readNow && !chipEnN && addrPin == `DPM_MAIL_LOW) intInN <= 1'b1;
        if (farSetInt) intInN <= 1'b0;
        // far read of its own mailbox; a same-cycle write below still sets
        if (farClrInt) otherIntN <= 1'b1;
        if (wrMem && (rdWrN || chipEnN)) begin
            mem[wrAddr] <= wrData;
            if (wrAddr == `DPM_MAIL_TOP) otherIntN <= 1'b0;
        end
        if (wrTok && (rdWrN || tokenEnN)) tok_write(int'(wrAddr[2:0]), wrData[0]);
        for (int i = 0; i < 8; i++) if (farReq[i] != reqPrev[i]) far_edge(i, farReq[i]);
        reqPrev <= farReq;
        wrMem <= !chipEnN && !rdWrN;
        wrTok <= !tokenEnN && !rdWrN;
        wrAddr <= addrPin;
        wrData <= dataOut;
    end
endmodule : dpm_device_model

// >>> tb/tb.sv
/*
 * Self-checking bench for one port host against the device model.
 * Assumes the host drives the left port; the far port is scripted here.
 */
`timescale 1ns/1ps
`include "dpm_params.svh"

module tb;
    typedef struct {dpm_pkg::op_t op; logic [12:0] a; logic [7:0] d, e; logic g;} row_t;
    logic sys_clk, sys_rst, cmdValid, cmdReady, rspValid, rspGranted, rspStalled;
    logic initDone, mailboxPending, chipEnN, tokenEnN, rdWrN, outEnN, dataOe;
    logic busyInN, intInN, otherIntN, farSetInt, farClrInt, gotGrant;
    dpm_pkg::op_t cmdOp;
    logic [12:0] cmdAddr, addrPin;
    logic [7:0] cmdData, rspData, dataIn, dataOut, farReq, gotData;
    int mismatches = 0, checks = 0;
    row_t rows [8] = '{
        '{dpm_pkg::OP_MEM_WR, 13'h0010, 8'hA5, 8'h00, 1'b0},
        '{dpm_pkg::OP_MEM_RD, 13'h0010, 8'h00, 8'hA5, 1'b0},
        '{dpm_pkg::OP_MEM_WR, 13'h1FFF, 8'hC3, 8'h00, 1'b0},
        '{dpm_pkg::OP_MEM_RD, 13'h1FFF, 8'h00, 8'hC3, 1'b0},
        '{dpm_pkg::OP_TOKEN_TAKE, 13'h000B, 8'h00, 8'h00, 1'b1},
        '{dpm_pkg::OP_TOKEN_POLL, 13'h0003, 8'h00, 8'h00, 1'b1},
        '{dpm_pkg::OP_TOKEN_GIVE, 13'h0003, 8'h00, 8'h00, 1'b0},
        '{dpm_pkg::OP_TOKEN_POLL, 13'h0003, 8'h00, 8'hFF, 1'b0}};
    dpm_port_host #(.ADDR_W(13), .DATA_W(8), .LEFT_PORT(1'b1)) dut_u (.sys_clk(sys_clk),
        .sys_rst(sys_rst), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp),
        .cmdAddr(cmdAddr), .cmdData(cmdData), .rspValid(rspValid), .rspData(rspData),
        .rspGranted(rspGranted), .rspStalled(rspStalled), .initDone(initDone),
        .mailboxPending(mailboxPending), .chipEnN(chipEnN), .tokenEnN(tokenEnN),
        .rdWrN(rdWrN), .outEnN(outEnN), .addrPin(addrPin), .dataIn(dataIn),
        .dataOut(dataOut), .dataOe(dataOe), .busyInN(busyInN), .intInN(intInN));
    dpm_device_model model_u (.sys_clk(sys_clk), .chipEnN(chipEnN), .tokenEnN(tokenEnN),
        .rdWrN(rdWrN), .outEnN(outEnN), .addrPin(addrPin), .dataOut(dataOut),
        .dataIn(dataIn), .intInN(intInN), .otherIntN(otherIntN), .farReq(farReq),
        .farSetInt(farSetInt), .farClrInt(farClrInt));
    always #2 sys_clk = ~sys_clk;
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // entered and left just after a rising edge
    task automatic issue(input dpm_pkg::op_t op, input logic [12:0] a, input logic [7:0] d);
        int n = 0;
        cmdOp = op; cmdAddr = a; cmdData = d; cmdValid = 1'b1;
        @(negedge sys_clk);
        while (cmdReady !== 1'b1 && n < 400) begin n++; @(negedge sys_clk); end
        chk("command taken", 8'h00, {7'h00, n == 400});
        @(posedge sys_clk); #1 cmdValid = 1'b0;
    endtask : issue
    task automatic finish();
        int n = 0;
        @(negedge sys_clk);
        while (rspValid !== 1'b1 && n < 200) begin n++; @(negedge sys_clk); end
        chk("response seen", 8'h00, {7'h00, n == 200});
        gotData = rspData; gotGrant = rspGranted;
        @(posedge sys_clk); #1;
    endtask : finish
    task automatic tok(input dpm_pkg::op_t op, input logic [12:0] a, input logic g);
        issue(op, a, 8'h00); finish();
        if (op != dpm_pkg::OP_TOKEN_GIVE) chk("token grant", {7'h00, g}, {7'h00, gotGrant});
    endtask : tok
    task automatic wrap_up();
        if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    initial begin
        #80000; mismatches++; wrap_up();
    end
    initial begin
        sys_clk = 1'b0; sys_rst = 1'b1; cmdValid = 1'b0; cmdOp = dpm_pkg::OP_MEM_RD;
        cmdAddr = 13'h0000; cmdData = 8'h00; busyInN = 1'b1; farReq = 8'h00; farSetInt = 1'b0;
        farClrInt = 1'b0;
        repeat (12) @(posedge sys_clk);
        #1 chk("idle pins", 8'h06, {5'h00, chipEnN, tokenEnN, dataOe});
        chk("init pending", 8'h00, {7'h00, initDone});
        sys_rst = 1'b0;
        foreach (rows[i]) begin
            issue(rows[i].op, rows[i].a, rows[i].d); finish();
            if (rows[i].op inside {dpm_pkg::OP_MEM_RD, dpm_pkg::OP_TOKEN_TAKE,
                dpm_pkg::OP_TOKEN_POLL}) chk("read data", rows[i].e, gotData);
            if (rows[i].op inside {dpm_pkg::OP_TOKEN_TAKE, dpm_pkg::OP_TOKEN_POLL})
                chk("grant", {7'h00, rows[i].g}, {7'h00, gotGrant});
        end
        chk("init done", 8'h01, {7'h00, initDone});
        chk("far mailbox flag", 8'h00, {7'h00, otherIntN});
        farClrInt = 1'b1; @(posedge sys_clk); #1 farClrInt = 1'b0;
        chk("far mailbox cleared", 8'h01, {7'h00, otherIntN});
        farSetInt = 1'b1; @(posedge sys_clk); #1 farSetInt = 1'b0;
        repeat (4) @(posedge sys_clk);
        #1 chk("mailbox raised", 8'h01, {7'h00, mailboxPending});
        issue(dpm_pkg::OP_MEM_RD, `DPM_MAIL_LOW, 8'h00); finish();
        repeat (4) @(posedge sys_clk);
        #1 chk("mailbox cleared", 8'h00, {7'h00, mailboxPending});
        tok(dpm_pkg::OP_TOKEN_TAKE, 13'h0002, 1'b1); farReq[2] = 1'b1;
        tok(dpm_pkg::OP_TOKEN_POLL, 13'h0002, 1'b1);
        tok(dpm_pkg::OP_TOKEN_GIVE, 13'h0002, 1'b0);
        tok(dpm_pkg::OP_TOKEN_POLL, 13'h0002, 1'b0); farReq[2] = 1'b0;
        farReq[4] = 1'b1; tok(dpm_pkg::OP_TOKEN_TAKE, 13'h0004, 1'b0); farReq[4] = 1'b0;
        tok(dpm_pkg::OP_TOKEN_POLL, 13'h0004, 1'b1);
        farReq[6] = 1'b1; tok(dpm_pkg::OP_TOKEN_TAKE, 13'h0006, 1'b0);
        tok(dpm_pkg::OP_TOKEN_GIVE, 13'h0006, 1'b0); farReq[6] = 1'b0;
        tok(dpm_pkg::OP_TOKEN_POLL, 13'h0006, 1'b0);
        busyInN = 1'b0; // master arbitration loss seen by this slave
        issue(dpm_pkg::OP_MEM_WR, 13'h0020, 8'h77);
        repeat (30) @(posedge sys_clk);
        #1 chk("write held off", 8'h01, {7'h00, rdWrN});
        busyInN = 1'b1; finish();
        chk("stall flag", 8'h01, {7'h00, rspStalled});
        issue(dpm_pkg::OP_MEM_RD, 13'h0020, 8'h00); finish();
        chk("late write data", 8'h77, gotData);
        wrap_up();
    end
endmodule : tb
